// [rtl/ucd_pkg.sv]
// constants for the charger port detection block
package ucd_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] UCD_OFS_CTRL   = 8'h04;  // bit 4: detection force
  localparam logic [7:0] UCD_OFS_DPLUS  = 8'h07;  // bit 4: d+ source clear
  localparam logic [7:0] UCD_OFS_STATUS = 8'h10;
  localparam logic [7:0] UCD_OFS_MODE   = 8'h14;  // bit 0: host mode
  localparam int UCD_BIT_FORCE = 4;
  localparam int UCD_BIT_CLEAR = 4;
  localparam int UCD_BIT_HOST  = 0;
  // input limit codes
  localparam logic [2:0] UCD_LIM_100  = 3'h0;
  localparam logic [2:0] UCD_LIM_500  = 3'h1;
  localparam logic [2:0] UCD_LIM_1500 = 3'h2;
  localparam logic [2:0] UCD_LIM_2000 = 3'h3;
  localparam logic [2:0] UCD_LIM_EXT  = 3'h4;
  localparam logic [2:0] UCD_LIM_HIZ  = 3'h5;
  localparam logic [2:0] UCD_LIM_ZERO = 3'h6;
  // timer codes
  localparam logic [1:0] UCD_TMR_NONE = 2'h0;
  localparam logic [1:0] UCD_TMR_45M  = 2'h1;
  localparam logic [1:0] UCD_TMR_6H   = 2'h2;
  // voltage floor codes
  localparam logic [1:0] UCD_VFL_436  = 2'h0;
  localparam logic [1:0] UCD_VFL_EXT  = 2'h1;
  localparam logic [1:0] UCD_VFL_NONE = 2'h2;
  // port types
  localparam logic [2:0] UCD_PORT_NONE = 3'h0;
  localparam logic [2:0] UCD_PORT_DCP  = 3'h1;
  localparam logic [2:0] UCD_PORT_CDP  = 3'h2;
  localparam logic [2:0] UCD_PORT_SDP  = 3'h3;
  localparam logic [2:0] UCD_PORT_NSTD = 3'h4;
  localparam logic [2:0] UCD_PORT_ACA  = 3'h5;
  // timing
  localparam int UCD_CLK_MHZ    = 100;
  localparam int UCD_DCD_US     = 900;
  localparam int UCD_DCD_CYCLES = UCD_DCD_US * UCD_CLK_MHZ;
  localparam int UCD_CONN_MS     = 1000;
  localparam int UCD_CONN_CYCLES = UCD_CONN_MS * 1000 * UCD_CLK_MHZ;
  typedef enum logic [5:0] {
    UCD_IDLE = 6'b00_0001,
    UCD_DCD  = 6'b00_0010,
    UCD_PRI  = 6'b00_0100,
    UCD_SEC  = 6'b00_1000,
    UCD_NSTD = 6'b01_0000,
    UCD_CFG  = 6'b10_0000
  } ucd_state_type;
endpackage

// [rtl/ucd_port_detect.sv]
// charger port detection and input-setting selection
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Contract
// - grounded limit pin turns the external limit into 2A; grounded floor pin gives 4.36V.
// - grounded charge-set pin flags a fault and suspends charging.
// - floating limit pin with external charge setting gives zero charge current.
// - detection runs by itself only in standalone mode.
// - host mode: writing 1 to bit 4 of 0x04 starts detection.
// - host mode never applies the detected input limit.
// - detection runs first; select pins act only after a later change.
// - detection is a six-state machine.
// - contact detect entered on vbus insertion standalone, or on force bit.
// - contact timer expiry goes to non-standard check, else primary.
// - primary picks dcp/cdp check or sdp/non-standard check.
// - non-standard pass goes to configure, otherwise back to primary.
// - after secondary classification go to configure.
// - configure sets limit and timer; dcp gets external limit, 6 hours.
// - cdp or sdp with dead battery: 100 mA and 45 minutes.
// - good battery: cdp 1500mA 6h, sdp hi-z none, non-standard 500mA 6h.
// - accessory adapter on otg port defaults to 500mA.
// - drive d+ voltage during battery wakeup.
// - writing 1 to bit 4 of 0x07 removes d+ voltage.
// - standalone pins: 00 500mA, 01 external, 10 100mA, 11 hi-z.
// - power-good stays high impedance until detection completes.
module ucd_port_detect #(
  parameter int DCD_CYCLES  = ucd_pkg::UCD_DCD_CYCLES,
  parameter int CONN_CYCLES = ucd_pkg::UCD_CONN_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // pins and analog comparator results
  input  wire logic        vbus_present,
  input  wire logic        watchdog_expired,
  input  wire logic        data_contact,
  input  wire logic        primary_hit,
  input  wire logic        secondary_hit,
  input  wire logic        nstd_match,
  input  wire logic        aca_otg,
  input  wire logic        battery_good,
  input  wire logic        current_select_pin_a,
  input  wire logic        current_select_pin_b,
  input  wire logic        input_limit_set_pin_gnd,
  input  wire logic        input_limit_set_pin_float,
  input  wire logic        input_voltage_floor_pin_gnd,
  input  wire logic        charge_current_set_pin_gnd,
  input  wire logic        ext_charge_sel,
  // outputs
  output logic      [2:0]  input_limit,
  output logic      [1:0]  charge_timer,
  output logic      [1:0]  voltage_floor,
  output logic             charge_fault,
  output logic             charge_suspend,
  output logic             charge_zero,
  output logic             dplus_src_en,
  output logic             power_good_output,
  output logic             power_good_output_oe_n,
  output logic             conn_deadline
);
  import ucd_pkg::*;

  initial begin
    if (DCD_CYCLES < 2 || CONN_CYCLES < 2) $error("counts too small");
  end

  // two-flop synchronisers for every pin-side input except ext_charge_sel
  localparam int NS = 14;
  logic [NS-1:0] raw, s1_q, s2_q;
  assign raw = {vbus_present, watchdog_expired, data_contact, primary_hit, secondary_hit, nstd_match,
                aca_otg, battery_good, current_select_pin_a, current_select_pin_b, input_limit_set_pin_gnd,
                input_limit_set_pin_float, input_voltage_floor_pin_gnd, charge_current_set_pin_gnd};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else if (clk_en) begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end
  logic vb, wd, dc, ph, sh, nm, ao, bg, ea, eb, lg, lf, fg, cg;
  assign {vb, wd, dc, ph, sh, nm, ao, bg, ea, eb, lg, lf, fg, cg} = s2_q;

  // state
  ucd_state_type st_q, st_d;
  logic [31:0]   cnt_q, cnt_d;
  logic          vb_q, sel_dcp_q, sel_dcp_d;
  logic [2:0]    port_q, port_d;
  logic          done_q, done_d;
  logic          host_q, host_d;
  logic          dp_q, dp_d;
  logic [1:0]    pins_q, pins_d;
  logic          pins_live_q, pins_live_d;
  logic [31:0]   conn_q, conn_d;
  logic          force_pulse, clear_pulse, standalone, start;

  assign force_pulse = clk_en && reg_wr && reg_addr == UCD_OFS_CTRL && reg_wdata[UCD_BIT_FORCE];
  assign clear_pulse = clk_en && reg_wr && reg_addr == UCD_OFS_DPLUS && reg_wdata[UCD_BIT_CLEAR];
  assign standalone  = !host_q && wd;
  assign start       = (standalone && vb && !vb_q) || force_pulse;

  always_comb begin
    st_d        = st_q;
    cnt_d       = cnt_q;
    sel_dcp_d   = sel_dcp_q;
    port_d      = port_q;
    done_d      = done_q;
    host_d      = host_q;
    dp_d        = dp_q;
    pins_d      = pins_q;
    pins_live_d = pins_live_q;
    conn_d      = (conn_q != 32'h0000_0000) ? conn_q - 32'h0000_0001 : conn_q;
    if (reg_wr && reg_addr == UCD_OFS_MODE) begin
      host_d = reg_wdata[UCD_BIT_HOST];
    end
    if (clear_pulse && dp_q) begin
      dp_d   = 1'b0;
      conn_d = CONN_CYCLES[31:0];
    end
    if (done_q && {eb, ea} != pins_q) begin
      pins_live_d = 1'b1;
      pins_d      = {eb, ea};
    end
    unique case (st_q)
      UCD_IDLE: begin
        if (start) begin
          st_d  = UCD_DCD;
          cnt_d = 32'h0000_0000;
          // clear done; it stays low until the new run finishes
          done_d = 1'b0;
        end
      end
      UCD_DCD: begin
        cnt_d = cnt_q + 32'h0000_0001;
        if (dc) begin
          st_d = UCD_PRI;
        end else if (cnt_q >= DCD_CYCLES[31:0] - 32'h0000_0001) begin
          st_d = UCD_NSTD;
        end
      end
      UCD_PRI: begin
        sel_dcp_d = ph;
        st_d      = UCD_SEC;
      end
      UCD_SEC: begin
        if (ao) begin
          port_d = UCD_PORT_ACA;
        end else if (sel_dcp_q) begin
          port_d = sh ? UCD_PORT_DCP : UCD_PORT_CDP;
        end else begin
          port_d = sh ? UCD_PORT_NSTD : UCD_PORT_SDP;
        end
        st_d = UCD_CFG;
      end
      UCD_NSTD: begin
        if (nm) begin
          port_d = UCD_PORT_NSTD;
          st_d   = UCD_CFG;
        end else begin
          st_d = UCD_PRI;
        end
      end
      UCD_CFG: begin
        done_d      = 1'b1;
        pins_d      = {eb, ea};
        pins_live_d = 1'b0;
        st_d        = UCD_IDLE;
        if (!bg && (port_q == UCD_PORT_SDP || port_q == UCD_PORT_CDP)) begin
          dp_d = 1'b1;
        end
      end
      default: begin
        st_d = UCD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q        <= UCD_IDLE;
      cnt_q       <= 32'h0000_0000;
      vb_q        <= 1'b0;
      sel_dcp_q   <= 1'b0;
      port_q      <= UCD_PORT_NONE;
      done_q      <= 1'b0;
      host_q      <= 1'b0;
      dp_q        <= 1'b0;
      pins_q      <= 2'h0;
      pins_live_q <= 1'b0;
      conn_q      <= 32'h0000_0000;
    end else if (clk_en) begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      vb_q        <= vb;
      sel_dcp_q   <= sel_dcp_d;
      port_q      <= port_d;
      done_q      <= done_d;
      host_q      <= host_d;
      dp_q        <= dp_d;
      pins_q      <= pins_d;
      pins_live_q <= pins_live_d;
      conn_q      <= conn_d;
    end
  end

  // settings: detection result, then pins once they changed
  logic [2:0] lim_det, lim_sel;
  logic [1:0] tmr_det;
  always_comb begin
    lim_det = UCD_LIM_500;
    tmr_det = UCD_TMR_NONE;
    unique case (port_q)
      UCD_PORT_DCP: begin
        lim_det = UCD_LIM_EXT;
        tmr_det = UCD_TMR_6H;
      end
      UCD_PORT_CDP: begin
        lim_det = bg ? UCD_LIM_1500 : UCD_LIM_100;
        tmr_det = bg ? UCD_TMR_6H : UCD_TMR_45M;
      end
      UCD_PORT_SDP: begin
        lim_det = bg ? UCD_LIM_HIZ : UCD_LIM_100;
        tmr_det = bg ? UCD_TMR_NONE : UCD_TMR_45M;
      end
      UCD_PORT_NSTD: begin
        lim_det = UCD_LIM_500;
        tmr_det = UCD_TMR_6H;
      end
      UCD_PORT_ACA: begin
        lim_det = UCD_LIM_500;
        tmr_det = UCD_TMR_6H;
      end
      default: begin
        lim_det = UCD_LIM_500;
        tmr_det = UCD_TMR_NONE;
      end
    endcase
    lim_sel = lim_det;
    if (host_q || !done_q) begin
      lim_sel = UCD_LIM_500;
    end else if (pins_live_q) begin
      unique case (pins_q)
        2'b00: lim_sel = UCD_LIM_500;
        2'b01: lim_sel = UCD_LIM_EXT;
        2'b10: lim_sel = UCD_LIM_100;
        default: lim_sel = UCD_LIM_HIZ;
      endcase
    end
    if (lim_sel == UCD_LIM_EXT && lg) begin
      lim_sel = UCD_LIM_2000;
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_limit   <= UCD_LIM_500;
      charge_timer  <= UCD_TMR_NONE;
      voltage_floor <= UCD_VFL_436;
      reg_rdata     <= 8'h00;
    end else if (clk_en) begin
      input_limit   <= lim_sel;
      charge_timer  <= tmr_det;
      if (lim_sel == UCD_LIM_HIZ) begin
        voltage_floor <= UCD_VFL_NONE;
      end else if (lim_sel == UCD_LIM_EXT || lim_sel == UCD_LIM_2000) begin
        voltage_floor <= fg ? UCD_VFL_436 : UCD_VFL_EXT;
      end else begin
        voltage_floor <= UCD_VFL_436;
      end
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          UCD_OFS_STATUS: reg_rdata <= {done_q, dp_q, st_q == UCD_IDLE, 2'b00, port_q};
          UCD_OFS_MODE:   reg_rdata <= {7'h00, host_q};
          default:        reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign charge_fault           = cg;
  assign charge_suspend         = cg;
  assign charge_zero            = lf && ext_charge_sel;
  assign dplus_src_en           = dp_q;
  assign power_good_output      = 1'b0;
  assign power_good_output_oe_n = !(done_q && vb);
  assign conn_deadline          = conn_q != 32'h0000_0000;

  property p_dcd_timeout;
    @(posedge clk) disable iff (!rst_n) (clk_en && st_q == UCD_DCD && !dc && cnt_q == DCD_CYCLES - 1)
      |=> st_q == UCD_NSTD;
  endproperty
  a_dcd_timeout: assert property (p_dcd_timeout) else $error("contact timeout not taken");
  property p_force;
    @(posedge clk) disable iff (!rst_n) (force_pulse && st_q == UCD_IDLE) |=> st_q == UCD_DCD;
  endproperty
  a_force: assert property (p_force) else $error("force did not start");
  property p_sec_cfg;
    @(posedge clk) disable iff (!rst_n) (clk_en && st_q == UCD_SEC) |=> st_q == UCD_CFG;
  endproperty
  a_sec_cfg: assert property (p_sec_cfg) else $error("secondary not followed by config");
  property p_nstd_back;
    @(posedge clk) disable iff (!rst_n) (clk_en && st_q == UCD_NSTD && !nm) |=> st_q == UCD_PRI;
  endproperty
  a_nstd_back: assert property (p_nstd_back) else $error("non-standard fail not back");
  property p_pg;
    @(posedge clk) disable iff (!rst_n) !done_q |-> power_good_output_oe_n;
  endproperty
  a_pg: assert property (p_pg) else $error("power good driven early");
  property p_host;
    @(posedge clk) disable iff (!rst_n) (clk_en && host_q) |=> input_limit == UCD_LIM_500;
  endproperty
  a_host: assert property (p_host) else $error("host mode applied detected limit");
  property p_clear;
    @(posedge clk) disable iff (!rst_n) (clear_pulse && dp_q) |=> !dplus_src_en && conn_deadline;
  endproperty
  a_clear: assert property (p_clear) else $error("d+ not cleared");
  property p_zero;
    @(posedge clk) disable iff (!rst_n) charge_zero == (lf && ext_charge_sel);
  endproperty
  a_zero: assert property (p_zero) else $error("zero charge mismatch");
  property p_hold;
    @(posedge clk) disable iff (!rst_n) (clk_en && st_q == UCD_IDLE && !start) |=> port_q == $past(port_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed while idle");
  property p_one_hot;
    @(posedge clk) disable iff (!rst_n) $onehot(st_q);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("state not one-hot");
endmodule

// [tb/ucd_port_detect_bench.sv]
// self-checking bench for the charger port detection block
`timescale 1ns/10ps
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin num_errors++; $display("ERROR %s exp %0h got %0h", n, e, s); end end
module ucd_port_detect_bench;
  import ucd_pkg::*;
  logic       clk, rst_n, wr, rd, vbus, wdog, aca, batt, pa, pb;
  logic       lgnd, lflt, fgnd, ignd, extc, dc, ph, sh, nm;
  logic       flt, susp, zero, dp, pg, pg_oe_n, cdl;
  logic [7:0] addr, wdata, rdata, rv;
  logic [2:0] lim, kind;
  logic [1:0] tmr, vfl;
  int         num_errors, num_checks;
  logic [2:0] t_kind [6] = '{UCD_PORT_CDP, UCD_PORT_CDP, UCD_PORT_SDP, UCD_PORT_SDP, UCD_PORT_NSTD, UCD_PORT_NONE};
  logic       t_good [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic [2:0] t_lim [6] = '{UCD_LIM_1500, UCD_LIM_100, UCD_LIM_HIZ, UCD_LIM_100, UCD_LIM_500, UCD_LIM_500};
  logic [1:0] t_tmr [6] = '{UCD_TMR_6H, UCD_TMR_45M, UCD_TMR_NONE, UCD_TMR_45M, UCD_TMR_6H, UCD_TMR_6H};
  logic [1:0] p_code [4] = '{2'b11, 2'b00, 2'b10, 2'b01};
  logic [2:0] p_lim [4] = '{UCD_LIM_HIZ, UCD_LIM_500, UCD_LIM_100, UCD_LIM_EXT};
  logic [1:0] p_vfl [4] = '{UCD_VFL_NONE, UCD_VFL_436, UCD_VFL_436, UCD_VFL_EXT};

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  ucd_port_detect #(.DCD_CYCLES(20), .CONN_CYCLES(50)) dut (
    .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr),
    .reg_rd(rd), .reg_rdata(rdata), .vbus_present(vbus), .watchdog_expired(wdog), .data_contact(dc),
    .primary_hit(ph), .secondary_hit(sh), .nstd_match(nm), .aca_otg(aca), .battery_good(batt),
    .current_select_pin_a(pa), .current_select_pin_b(pb), .input_limit_set_pin_gnd(lgnd),
    .input_limit_set_pin_float(lflt), .input_voltage_floor_pin_gnd(fgnd),
    .charge_current_set_pin_gnd(ignd), .ext_charge_sel(extc), .input_limit(lim), .charge_timer(tmr),
    .voltage_floor(vfl), .charge_fault(flt), .charge_suspend(susp), .charge_zero(zero),
    .dplus_src_en(dp), .power_good_output(pg), .power_good_output_oe_n(pg_oe_n), .conn_deadline(cdl));

  ucd_usb_port_model port (.attached(vbus), .kind(kind), .data_contact(dc), .primary_hit(ph),
    .secondary_hit(sh), .nstd_match(nm));

  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    rv = rdata;
  endtask

  // skip the first cycles so a stale done from the last run is not seen
  task automatic wait_done();
    int n;
    n = 0;
    tick(4);
    do begin
      rd_reg(UCD_OFS_STATUS);
      n++;
    end while (!(rv[7] === 1'b1 && rv[5] === 1'b1) && n < 300);
    if (n >= 300) begin
      num_errors++;
      give_verdict();
    end
    tick(2);
  endtask

  initial begin
    {rst_n, wr, rd, vbus, aca, pa, lgnd, lflt, fgnd, ignd, extc} = '0;
    {wdog, batt, pb} = 3'b111;
    addr = 8'h00;
    wdata = 8'h00;
    kind = UCD_PORT_DCP;
    num_errors = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK("rst limit", UCD_LIM_500, lim)
    `CHK("rst timer", UCD_TMR_NONE, tmr)
    `CHK("rst floor", UCD_VFL_436, vfl)
    `CHK("rst pg oe_n", 1'b1, pg_oe_n)
    vbus <= 1'b1;
    wait_done();
    `CHK("auto port", UCD_PORT_DCP, rv[2:0])
    `CHK("dcp limit", UCD_LIM_EXT, lim)
    `CHK("dcp timer", UCD_TMR_6H, tmr)
    `CHK("pg oe_n", 1'b0, pg_oe_n)
    `CHK("pg level", 1'b0, pg)
    $display("test auto detection done");
    for (int i = 0; i < 4; i++) begin
      {pb, pa} <= p_code[i];
      tick(6);
      `CHK("pin limit", p_lim[i], lim)
      `CHK("pin floor", p_vfl[i], vfl)
    end
    lgnd <= 1'b1;
    fgnd <= 1'b1;
    tick(6);
    `CHK("lim gnd", UCD_LIM_2000, lim)
    `CHK("floor gnd", UCD_VFL_436, vfl)
    ignd <= 1'b1;
    lgnd <= 1'b0;
    lflt <= 1'b1;
    extc <= 1'b1;
    tick(6);
    `CHK("fault", 1'b1, flt)
    `CHK("suspend", 1'b1, susp)
    `CHK("zero chg", 1'b1, zero)
    {ignd, extc, fgnd} <= 3'b000;
    tick(6);
    `CHK("fault off", 1'b0, flt)
    `CHK("zero off", 1'b0, zero)
    $display("test setting pins done");
    for (int i = 0; i < 6; i++) begin
      kind <= t_kind[i];
      batt <= t_good[i];
      tick(4);
      wr_reg(UCD_OFS_CTRL, 8'h10);
      wait_done();
      `CHK("port", (t_kind[i] == UCD_PORT_NONE) ? UCD_PORT_NSTD : t_kind[i], rv[2:0])
      `CHK("limit", t_lim[i], lim)
      `CHK("timer", t_tmr[i], tmr)
      if (!t_good[i]) begin
        `CHK("dplus on", 1'b1, dp)
        wr_reg(UCD_OFS_DPLUS, 8'h10);
        tick(2);
        `CHK("dplus off", 1'b0, dp)
        `CHK("deadline", 1'b1, cdl)
        tick(50);
        `CHK("deadline end", 1'b0, cdl)
      end
    end
    $display("test forced detection done");
    kind <= UCD_PORT_DCP;
    aca  <= 1'b1;
    tick(4);
    wr_reg(UCD_OFS_CTRL, 8'h10);
    wait_done();
    `CHK("aca limit", UCD_LIM_500, lim)
    aca  <= 1'b0;
    $display("test accessory adapter done");
    wr_reg(UCD_OFS_MODE, 8'h01);
    rd_reg(UCD_OFS_MODE);
    `CHK("host bit", 1'b1, rv[0])
    kind <= UCD_PORT_CDP;
    tick(4);
    wr_reg(UCD_OFS_CTRL, 8'h10);
    wait_done();
    `CHK("host port", UCD_PORT_CDP, rv[2:0])
    `CHK("host limit", UCD_LIM_500, lim)
    vbus <= 1'b0;
    kind <= UCD_PORT_SDP;
    tick(10);
    vbus <= 1'b1;
    tick(60);
    rd_reg(UCD_OFS_STATUS);
    `CHK("held port", UCD_PORT_CDP, rv[2:0])
    rd_reg(8'h3f);
    `CHK("unmapped", 8'h00, rv)
    $display("test host mode done");
    give_verdict();
  end
endmodule

// [tb/ucd_usb_port_model.sv]
// usb host port or adapter model seen on the d+/d- comparators
`timescale 1ns/10ps
module ucd_usb_port_model
  import ucd_pkg::*;
(
  // far side selection
  input  wire logic       attached,
  input  wire logic [2:0] kind,
  // comparator results
  output logic            data_contact,
  output logic            primary_hit,
  output logic            secondary_hit,
  output logic            nstd_match
);
  import ucd_pkg::*;
  // detached lines fall to the pull-down level
  assign data_contact  = attached && (kind != UCD_PORT_NONE);
  assign primary_hit   = attached && (kind == UCD_PORT_DCP || kind == UCD_PORT_CDP);
  assign secondary_hit = attached && (kind == UCD_PORT_DCP || kind == UCD_PORT_NSTD);
  // no contact but proprietary signature: the timeout path
  assign nstd_match    = attached && (kind == UCD_PORT_NONE);
endmodule
